//--- rtl/power_loss_state_control_consts.vh
// Purpose: constants for the power-loss state controller
// Assumes: 250 MHz system clock, classic Wishbone register access
// Notes:   offsets are byte addresses of 32-bit words
`ifndef POWER_LOSS_STATE_CONTROL_CONSTS_VH
`define POWER_LOSS_STATE_CONTROL_CONSTS_VH

// ***************************************
// operating states
// ***************************************
`define ST_W            3
`define ST_HOLD         3'h0
`define ST_SOFTSTART    3'h1
`define ST_NORMAL       3'h2
`define ST_HEALTH       3'h3
`define ST_SUPPLEMENT   3'h4
`define ST_SUPDIS       3'h5
`define ST_SHUTDOWN     3'h6

// ***************************************
// register map
// ***************************************
`define ADDR_STATE      4'h0
`define ADDR_STATUS     4'h4
`define ADDR_MASK       4'h8
`define ADDR_CONFIG     4'hc
`define NUM_SRC         13
`define MASK_RESET      13'h0000
`define OVSEL_RESET     3'h1
`define OVSEL_OFF       3'h0

// ***************************************
// status source bit positions
// ***************************************
`define SRC_IN_OV       0
`define SRC_IN_UV       1
`define SRC_TH_WARN     2
`define SRC_TH_SHUT     3
`define SRC_DROP        4
`define SRC_OC_WARN     5
`define SRC_OC_LIM      6
`define SRC_VB_BAD      7
`define SRC_STR_OV      8
`define SRC_STR_UV      9
`define SRC_SUPP        10
`define SRC_BUCK_FLT    11
`define SRC_BUCK_UV     12
`define SRC_REF_UV      12

// ***************************************
// timing
// ***************************************
`define CLK_MHZ         40'hfa
`define SS_TIME_US      1000
`define SS_CYCLES       (`SS_TIME_US * `CLK_MHZ)
`define HC_TIME_S       240
`define HC_CYCLES       (`HC_TIME_S * 1000000 * `CLK_MHZ)
`define CNT_W           40
`define THR_LOW_MV      640
`define DROP_SUPP_MV    300
`define DROP_SS_MV      200
`define DROP_OC_MV      560

`endif

//--- rtl/flag_sync.v
// Purpose: two-stage synchroniser for a vector of comparator flags
// Assumes: flags are quasi-static analog results
// Notes:   first stage feeds only the second
`timescale 1ns/10ps
module flag_sync #(
	parameter W = 8
) (
	// clock and reset
	input  wire         clk,
	input  wire         rstN,
	// flags
	input  wire [W-1:0] din,
	output wire [W-1:0] dout
);
	reg [W-1:0] stage1Reg;
	reg [W-1:0] stage2Reg;

	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge clk or negedge rstN) begin
				if (!rstN) begin
					stage1Reg[i] <= 1'b0;
					stage2Reg[i] <= 1'b0;
				end else begin
					stage1Reg[i] <= din[i];
					stage2Reg[i] <= stage1Reg[i];
				end
			end
		end
	endgenerate

	assign dout = stage2Reg;
endmodule

//--- rtl/power_loss_state_control.v
// Purpose: state sequencer, enable map and status outputs of a power-loss guard
// Assumes: analog comparators arrive as digital flags; Wishbone classic slave
// Notes:   over-threshold flag per select code is supplied by the analog side
`timescale 1ns/10ps
`include "power_loss_state_control_consts.vh"

// Operation
// - enable map per state: hold/shutdown off, softstart fuse+ref, normal adds boost+blocking
// - overcurrent with large drop, short, over/undervoltage open fuse and enter supplement
// - in 145-155 degree band fuse and blocking on, boost off, interrupt asserted
// - enable low at power arrival keeps disabled; rising enable starts softstart
// - enable falling with valid input enters supplement; depleted storage then disables
// - fuse closes with enable high and sense above low threshold; out of window opens
// - sense low threshold fixed at 0.64 V, not programmable
// - three-bit high threshold select; 000 disables overvoltage, others pick thresholds
// - storage_path_enable low disables blocking switch, buck and boost
// - any unmasked status change asserts interrupt low
// - interrupt released only after status read, stays asserted while fault persists
// - thirteen interrupt sources from input, thermal, fuse, storage, buck, reference
// - seven faults enter supplement: sense low, sense high, input ov, input uv, overcurrent, short, drop
// - softstart lasts until drop below 200 mV and 1 ms timer expired
// - health check entered automatically every four minutes in normal
// - current state readable in a status field
module power_loss_state_control #(
	parameter [`CNT_W-1:0] SS_COUNT = `SS_CYCLES,
	parameter [`CNT_W-1:0] HC_COUNT = `HC_CYCLES
) (
	// clock and reset
	input  wire        clk_sys,
	input  wire        arst_n,
	// wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// control pins
	input  wire        enablePin,
	input  wire        storage_path_enable,
	// comparator flags
	input  wire        inputPowerValid,
	input  wire        senseAboveLow,
	input  wire        senseAboveHigh,
	input  wire        inputOv,
	input  wire        inputUv,
	input  wire        fuseOcWarn,
	input  wire        fuseOcLimit,
	input  wire        dropOverOc,
	input  wire        dropOverSupp,
	input  wire        dropBelowSs,
	input  wire        busShort,
	input  wire        tempWarn,
	input  wire        tempBand,
	input  wire        tempShut,
	input  wire        storageGood,
	input  wire        storageDepleted,
	input  wire        storageOv,
	input  wire        storageUv,
	input  wire        blockSideBad,
	input  wire        buckFault,
	input  wire        buckUv,
	input  wire        refUv,
	input  wire        healthFail,
	// enables and status
	output reg         fuseEnable,
	output reg         boostEnable,
	output reg         buckEnable,
	output reg         blocking_switch,
	output reg         refEnable,
	output reg         healthActive,
	output reg         power_loss_flag,
	output reg         output_power_good,
	output reg         storage_power_good,
	output reg         interrupt_n_out,
	output reg  [2:0]  input_sense_high_threshold_select
);
	localparam NF = 24;

	// ***************************************
	// reset release
	// ***************************************
	reg rstMetaReg;
	reg rstReg;
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rstMetaReg <= 1'b0;
			rstReg     <= 1'b0;
		end else begin
			rstMetaReg <= 1'b1;
			rstReg     <= rstMetaReg;
		end
	end

	// ***************************************
	// input synchronisation
	// ***************************************
	wire [NF-1:0] rawFlags;
	wire [NF-1:0] sf;
	assign rawFlags = {healthFail, refUv, buckUv, buckFault, blockSideBad, storageUv,
		storageOv, storageDepleted, storageGood, tempShut, tempBand, tempWarn, busShort,
		dropBelowSs, dropOverSupp, dropOverOc, fuseOcLimit, fuseOcWarn, inputUv, inputOv,
		senseAboveHigh, senseAboveLow, inputPowerValid, enablePin};

	flag_sync #(
		.W(NF)
	) u_sync (
		.clk  (clk_sys),
		.rstN (rstReg),
		.din  (rawFlags),
		.dout (sf)
	);

	wire sEn      = sf[0];
	wire sPwr     = sf[1];
	wire sAbvLow  = sf[2];  // fixed 0.64 V comparator
	wire sAbvHigh = sf[3];
	wire sInOv    = sf[4];
	wire sInUv    = sf[5];
	wire sOcWarn  = sf[6];
	wire sOcLim   = sf[7];
	wire sDropOc  = sf[8];
	wire sDropSup = sf[9];
	wire sDropSs  = sf[10];
	wire sShort   = sf[11];
	wire sTWarn   = sf[12];
	wire sTBand   = sf[13];
	wire sTShut   = sf[14];
	wire sStrGood = sf[15];
	wire sStrDep  = sf[16];
	wire sStrOv   = sf[17];
	wire sStrUv   = sf[18];
	wire sVbBad   = sf[19];
	wire sBuckF   = sf[20];
	wire sBuckUv  = sf[21];
	wire sRefUv   = sf[22];
	wire sHFail   = sf[23];

	// ***************************************
	// registers
	// ***************************************
	reg [`ST_W-1:0]    stateReg;
	reg [`ST_W-1:0]    stateNext;
	reg [`NUM_SRC-1:0] statusReg;
	reg [`NUM_SRC-1:0] maskReg;
	reg [`NUM_SRC-1:0] prevSrcReg;
	reg [`CNT_W-1:0]   ssCntReg;
	reg [`CNT_W-1:0]   hcCntReg;
	reg                enPrevReg;

	wire ovArmed  = (input_sense_high_threshold_select != `OVSEL_OFF);
	wire senseHi  = ovArmed & sAbvHigh;
	wire ocTrip   = sOcLim & sDropOc;
	wire faultIn  = ~sAbvLow | senseHi | sInOv | sInUv | ocTrip | sShort | sDropSup;
	wire enRise   = sEn & ~enPrevReg;
	wire ssDone   = (ssCntReg >= SS_COUNT) & sDropSs;
	wire hcDue    = (hcCntReg >= HC_COUNT);

	// ***************************************
	// next state
	// ***************************************
	always @* begin
		stateNext = stateReg;
		case (stateReg)
			`ST_HOLD: begin
				if (enRise && sPwr && sAbvLow && !sTShut) begin
					stateNext = `ST_SOFTSTART;
				end
			end
			`ST_SOFTSTART: begin
				if (sTShut) begin
					stateNext = `ST_SHUTDOWN;
				end else if (!sEn || faultIn) begin
					stateNext = `ST_HOLD;
				end else if (ssDone) begin
					stateNext = `ST_NORMAL;
				end
			end
			`ST_NORMAL, `ST_HEALTH, `ST_SUPDIS: begin
				if (sTShut) begin
					stateNext = `ST_SHUTDOWN;
				end else if ((!sEn && sPwr) || faultIn) begin
					stateNext = `ST_SUPPLEMENT;
				end else if (stateReg == `ST_NORMAL && hcDue) begin
					stateNext = `ST_HEALTH;
				end else if (stateReg == `ST_HEALTH && (sHFail || !sStrGood)) begin
					stateNext = `ST_SUPDIS;
				end else if (stateReg == `ST_HEALTH) begin
					stateNext = `ST_NORMAL;
				end else if (stateReg == `ST_SUPDIS && sStrGood && !sTBand) begin
					stateNext = `ST_NORMAL;
				end else if (stateReg == `ST_NORMAL && (!sStrGood || sTBand)) begin
					stateNext = `ST_SUPDIS;
				end
			end
			`ST_SUPPLEMENT: begin
				if (sTShut) begin
					stateNext = `ST_SHUTDOWN;
				end else if (sStrDep || sBuckUv) begin
					stateNext = `ST_HOLD;
				end else begin
					stateNext = `ST_SUPPLEMENT;
				end
			end
			`ST_SHUTDOWN: begin
				if (sTShut || sOcLim) begin
					stateNext = `ST_SHUTDOWN;
				end else if (sEn && sAbvLow) begin
					stateNext = `ST_SOFTSTART;
				end else begin
					stateNext = `ST_HOLD;
				end
			end
			default: begin
				stateNext = `ST_HOLD;
			end
		endcase
	end

	// ***************************************
	// state, timers, outputs
	// ***************************************
	wire [`NUM_SRC-1:0] src;
	assign src = {sRefUv | sBuckUv, sBuckF, stateReg == `ST_SUPPLEMENT, sStrUv, sStrOv,
		sVbBad, sOcLim, sOcWarn, sDropSup, sTShut, sTWarn | sTBand, sInUv, sInOv};

	wire busReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire statRead = busReq & ~wb_we_i & (wb_adr_i == `ADDR_STATUS);
	wire [`NUM_SRC-1:0] change = (src ^ prevSrcReg) & ~maskReg;
	// read clears, but a condition still present re-latches
	wire [`NUM_SRC-1:0] statusNext = (statRead ? (src & ~maskReg) : statusReg) | change;
	wire gate = storage_path_enable;
	wire isSupp = (stateNext == `ST_SUPPLEMENT);

	always @(posedge clk_sys or negedge rstReg) begin
		if (!rstReg) begin
			stateReg           <= `ST_HOLD;
			statusReg          <= {`NUM_SRC{1'b0}};
			prevSrcReg         <= {`NUM_SRC{1'b0}};
			ssCntReg           <= {`CNT_W{1'b0}};
			hcCntReg           <= {`CNT_W{1'b0}};
			enPrevReg          <= 1'b1;
			fuseEnable         <= 1'b0;
			boostEnable        <= 1'b0;
			buckEnable         <= 1'b0;
			blocking_switch    <= 1'b0;
			refEnable          <= 1'b0;
			healthActive       <= 1'b0;
			power_loss_flag    <= 1'b0;
			output_power_good  <= 1'b0;
			storage_power_good <= 1'b0;
			interrupt_n_out    <= 1'b1;
		end else begin
			stateReg   <= stateNext;
			enPrevReg  <= sEn;
			prevSrcReg <= src;
			statusReg  <= statusNext;
			ssCntReg   <= (stateReg == `ST_SOFTSTART && ssCntReg < SS_COUNT) ?
				ssCntReg + 1'b1 : ((stateReg == `ST_SOFTSTART) ? ssCntReg : {`CNT_W{1'b0}});
			hcCntReg   <= (stateReg == `ST_NORMAL && !hcDue) ?
				hcCntReg + 1'b1 : {`CNT_W{1'b0}};
			// registered enable map
			case (stateNext)
				`ST_SOFTSTART: begin
					{fuseEnable, boostEnable, buckEnable, blocking_switch, refEnable}
						<= 5'h11;
				end
				`ST_NORMAL, `ST_HEALTH: begin
					fuseEnable      <= 1'b1;
					boostEnable     <= gate & ~sTBand;
					buckEnable      <= 1'b0;
					blocking_switch <= gate;
					refEnable       <= 1'b1;
				end
				`ST_SUPPLEMENT: begin
					{fuseEnable, boostEnable, refEnable} <= 3'h1;
					buckEnable      <= gate;
					blocking_switch <= gate;
				end
				`ST_SUPDIS: begin
					fuseEnable      <= 1'b1;
					boostEnable     <= 1'b0;
					buckEnable      <= 1'b0;
					blocking_switch <= gate;
					refEnable       <= 1'b1;
				end
				default: begin
					{fuseEnable, boostEnable, buckEnable, blocking_switch, refEnable}
						<= 5'h00;
				end
			endcase
			healthActive       <= (stateNext == `ST_HEALTH);
			power_loss_flag    <= (stateNext == `ST_NORMAL) || (stateNext == `ST_HEALTH) ||
				(stateNext == `ST_SUPDIS);
			output_power_good  <= (stateNext == `ST_NORMAL) || (stateNext == `ST_HEALTH) ||
				(stateNext == `ST_SUPDIS);
			storage_power_good <= ((stateNext == `ST_NORMAL) || (stateNext == `ST_HEALTH) ||
				((stateNext == `ST_SUPDIS) && sTBand)) &
				sStrGood & gate & ~isSupp;
			interrupt_n_out    <= ~(|statusNext);
		end
	end

	// ***************************************
	// wishbone slave
	// ***************************************
	always @(posedge clk_sys or negedge rstReg) begin
		if (!rstReg) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			maskReg  <= `MASK_RESET;
			input_sense_high_threshold_select <= `OVSEL_RESET;
		end else begin
			wb_ack_o <= busReq;
			wb_dat_o <= 32'h00000000;
			if (busReq && wb_we_i && wb_sel_i[0]) begin
				if (wb_adr_i == `ADDR_MASK) begin
					maskReg[7:0] <= wb_dat_i[7:0];
				end
				if (wb_adr_i == `ADDR_CONFIG) begin
					input_sense_high_threshold_select <= wb_dat_i[2:0];
				end
			end
			if (busReq && wb_we_i && wb_sel_i[1] && wb_adr_i == `ADDR_MASK) begin
				maskReg[`NUM_SRC-1:8] <= wb_dat_i[`NUM_SRC-1:8];
			end
			if (busReq && !wb_we_i) begin
				case (wb_adr_i)
					`ADDR_STATE:  wb_dat_o <= {29'h0, stateReg};
					`ADDR_STATUS: wb_dat_o <= {19'h0, statusReg};
					`ADDR_MASK:   wb_dat_o <= {19'h0, maskReg};
					`ADDR_CONFIG: wb_dat_o <= {29'h0, input_sense_high_threshold_select};
					default:      wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end
endmodule

//--- dv/power_loss_state_control_chk.sv
// Purpose: port-level checks of the power-loss state controller
// Assumes: sees only the top module ports
// Notes:   bound to the top module below
`timescale 1ns/10ps
module power_loss_state_control_chk (
	// clock and reset
	input wire        clk_sys,
	input wire        arst_n,
	// bus
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [3:0]  wb_adr_i,
	input wire [3:0]  wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	// pins
	input wire        storage_path_enable,
	input wire        fuseEnable,
	input wire        boostEnable,
	input wire        buckEnable,
	input wire        blocking_switch,
	input wire        refEnable,
	input wire        interrupt_n_out,
	input wire [2:0]  input_sense_high_threshold_select
);
	// ****************
	// helpers
	// ****************
	reg [1:0] sinceRd;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	sequence busReq; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence statusRead; busReq ##0 (!wb_we_i && wb_adr_i == 4'h4); endsequence
	sequence cfgWrite; busReq ##0 (wb_we_i && wb_adr_i == 4'hc && wb_sel_i[0]); endsequence
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			sinceRd <= 2'h3;
		else if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == 4'h4)
			sinceRd <= 2'h0;
		else if (sinceRd != 2'h3)
			sinceRd <= sinceRd + 2'h1;
	end
	// ****************
	// assertions
	// ****************
	a_ack_follows: assert property (busReq |=> wb_ack_o) else $error("ack missing");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_dat_zero: assert property (wb_ack_o && (wb_we_i || wb_adr_i[1:0] != 2'h0)
		|-> wb_dat_o == 32'h0) else $error("stray read data");
	a_cfg_write: assert property (cfgWrite |=> input_sense_high_threshold_select
		== $past(wb_dat_i[2:0])) else $error("select not written");
	a_path_gate: assert property (!storage_path_enable [*2] |-> !boostEnable && !buckEnable
		&& !blocking_switch) else $error("storage path not gated");
	a_buck_map: assert property (buckEnable |-> !fuseEnable && !boostEnable && refEnable)
		else $error("buck map wrong");
	a_boost_map: assert property (boostEnable |-> fuseEnable && blocking_switch && refEnable)
		else $error("boost map wrong");
	a_irq_release: assert property ($rose(interrupt_n_out) |-> sinceRd != 2'h3)
		else $error("interrupt released without read");
endmodule
bind power_loss_state_control power_loss_state_control_chk chk_inst (.clk_sys, .arst_n,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.storage_path_enable, .fuseEnable, .boostEnable, .buckEnable, .blocking_switch,
	.refEnable, .interrupt_n_out, .input_sense_high_threshold_select);

//--- dv/host_model.sv
// Purpose: host processor model: bus master, enable pins, interrupt service
// Assumes: classic single-cycle bus
// Notes:   tasks are called from the bench
`timescale 1ns/10ps
module host_model (
	// clock
	input wire         clk,
	// bus master
	output reg         cyc,
	output reg         stb,
	output reg         we,
	output reg  [3:0]  adr,
	output reg  [3:0]  sel,
	output reg  [31:0] dat,
	input wire         ack,
	input wire  [31:0] datIn,
	// pins
	output reg         enablePin,
	output reg         storage_path_enable,
	input wire         interrupt_n_out
);
	initial begin
		{cyc, stb, we, adr, sel, dat} = 0;
		enablePin = 1'b0;
		storage_path_enable = 1'b0;
	end
	task xfer(input w, input [3:0] a, input [31:0] d, output [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		dat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = datIn;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// read status while the interrupt stands
	task service(output [31:0] st);
		integer i;
		reg [31:0] q;
		st = 0;
		for (i = 0; i < 8 && interrupt_n_out === 1'b0; i++) begin
			xfer(1'b0, 4'h4, 32'h0, q);
			st = st | q;
		end
	endtask
endmodule

//--- dv/power_loss_state_control_tb.sv
// Purpose: self-checking bench of the power-loss state controller
// Assumes: host model drives bus and enable pins
// Notes:   short soft-start and health counts
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin nFail++; \
	$display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module power_loss_state_control_tb;
	reg          clk_sys = 1'b0;
	reg          arst_n = 1'b0;
	reg  [22:0]  cmp = 23'h004203;
	wire         cyc, stb, we, ack;
	wire [3:0]   adr, sel;
	wire [31:0]  datW, datR;
	wire         fuseEnable, boostEnable, buckEnable, blocking_switch, refEnable;
	wire         power_loss_flag, storage_power_good, interrupt_n_out;
	wire         healthActive, outputPowerGood;
	wire [2:0]   ovSel;
	integer      nFail = 0, checks = 0, i, n;
	reg  [31:0]  q;
	reg  [68:0]  rows [0:21];
	reg  [22:0]  fm [0:7] = '{23'h2, 23'h4, 23'h8, 23'h10, 23'hc0, 23'h100, 23'h400, 23'h2000};
	reg  [7:0]   ex [0:7] = '{8'h38, 8'h38, 8'h38, 8'h38, 8'h38, 8'h38, 8'h38, 8'h00};
	reg  [22:0]  sm [0:7] = '{23'h800, 23'h1000, 23'h20, 23'h40000, 23'h10000, 23'h20000,
		23'h80000, 23'h200000};
	integer      sb [0:7] = '{2, 2, 5, 7, 8, 9, 11, 12};
	localparam   [22:0] BASE = 23'h004203;
	always #2 clk_sys = ~clk_sys;
	host_model host_inst (.clk(clk_sys), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
		.dat(datW), .ack(ack), .datIn(datR), .enablePin(), .storage_path_enable(),
		.interrupt_n_out(interrupt_n_out));
	power_loss_state_control #(.SS_COUNT(40'd20), .HC_COUNT(40'd400))
		power_loss_state_control_inst (.clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
		.wb_dat_o(datR), .wb_ack_o(ack), .enablePin(host_inst.enablePin),
		.storage_path_enable(host_inst.storage_path_enable), .inputPowerValid(cmp[0]),
		.senseAboveLow(cmp[1]), .senseAboveHigh(cmp[2]), .inputOv(cmp[3]), .inputUv(cmp[4]),
		.fuseOcWarn(cmp[5]), .fuseOcLimit(cmp[6]), .dropOverOc(cmp[7]),
		.dropOverSupp(cmp[8]), .dropBelowSs(cmp[9]), .busShort(cmp[10]), .tempWarn(cmp[11]),
		.tempBand(cmp[12]), .tempShut(cmp[13]), .storageGood(cmp[14]),
		.storageDepleted(cmp[15]), .storageOv(cmp[16]), .storageUv(cmp[17]),
		.blockSideBad(cmp[18]), .buckFault(cmp[19]), .buckUv(cmp[20]), .refUv(cmp[21]),
		.healthFail(cmp[22]), .fuseEnable(fuseEnable), .boostEnable(boostEnable),
		.buckEnable(buckEnable), .blocking_switch(blocking_switch), .refEnable(refEnable),
		.healthActive(healthActive), .power_loss_flag(power_loss_flag),
		.output_power_good(outputPowerGood),
		.storage_power_good(storage_power_good), .interrupt_n_out(interrupt_n_out),
		.input_sense_high_threshold_select(ovSel));
	task end_of_test;
		$display("checks %0d mismatches %0d", checks, nFail);
		if (nFail == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// disable, drain storage, enable again
	task restart;
		host_inst.enablePin <= 1'b0;
		repeat (8) @(posedge clk_sys);
		cmp <= BASE | 23'h8000;
		repeat (8) @(posedge clk_sys);
		host_inst.xfer(1'b0, 4'h0, 32'h0, q);
		`CHK(q, 32'h0)
		cmp <= BASE;
		host_inst.enablePin <= 1'b1;
		repeat (45) @(posedge clk_sys);
	endtask
	initial begin
		#40000;
		nFail++;
		end_of_test;
	end
	initial begin
		rows[0] = {4'h0, 1'b0, 32'h0, 32'h0};
		rows[1] = {4'h8, 1'b0, 32'h0, 32'h0};
		rows[2] = {4'hc, 1'b0, 32'h0, 32'h1};
		rows[3] = {4'h0, 1'b1, 32'h7, 32'h0};
		rows[4] = {4'h0, 1'b0, 32'h0, 32'h0};
		rows[5] = {4'h1, 1'b0, 32'h0, 32'h0};
		for (i = 0; i < 8; i++) begin
			rows[6 + 2 * i] = {4'hc, 1'b1, 32'(i), 32'h0};
			rows[7 + 2 * i] = {4'hc, 1'b0, 32'h0, 32'(i)};
		end
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		for (i = 0; i < 22; i++) begin
			host_inst.xfer(rows[i][64], rows[i][68:65], rows[i][63:32], q);
			`CHK(q, rows[i][31:0])
		end
		$display("register rows done");
		host_inst.enablePin <= 1'b1;
		repeat (8) @(posedge clk_sys);
		host_inst.xfer(1'b0, 4'h0, 32'h0, q);
		`CHK(q, 32'h1)
		`CHK({fuseEnable, boostEnable, buckEnable, blocking_switch, refEnable}, 5'h11)
		repeat (40) @(posedge clk_sys);
		host_inst.xfer(1'b0, 4'h0, 32'h0, q);
		`CHK(q, 32'h2)
		`CHK(outputPowerGood, 1'b1)
		`CHK({fuseEnable, boostEnable, buckEnable, blocking_switch, refEnable}, 5'h11)
		host_inst.storage_path_enable <= 1'b1;
		repeat (4) @(posedge clk_sys);
		`CHK({fuseEnable, boostEnable, buckEnable, blocking_switch, refEnable}, 5'h1b)
		host_inst.xfer(1'b1, 4'hc, 32'h0, q);
		cmp <= BASE ^ 23'h4;
		repeat (8) @(posedge clk_sys);
		`CHK(fuseEnable, 1'b1)
		cmp <= BASE;
		host_inst.xfer(1'b1, 4'hc, 32'h1, q);
		`CHK(ovSel, 3'h1)
		host_inst.enablePin <= 1'b0;
		repeat (6) @(posedge clk_sys);
		host_inst.xfer(1'b0, 4'h0, 32'h0, q);
		`CHK(q, 32'h4)
		$display("startup done");
		for (i = 0; i < 8; i++) begin
			restart;
			cmp <= BASE ^ fm[i];
			repeat (8) @(posedge clk_sys);
			`CHK({fuseEnable, boostEnable, buckEnable, blocking_switch, refEnable,
				power_loss_flag, storage_power_good, interrupt_n_out}, ex[i])
			cmp <= BASE;
		end
		$display("fault entry done");
		restart;
		host_inst.service(q);
		for (i = 0; i < 8; i++) begin
			cmp <= BASE ^ sm[i];
			repeat (8) @(posedge clk_sys);
			`CHK(interrupt_n_out, 1'b0)
			if (i == 1) begin
				`CHK({fuseEnable, boostEnable, blocking_switch}, 3'b101)
				`CHK(storage_power_good, 1'b1)
			end
			host_inst.service(q);
			`CHK(q[sb[i]], 1'b1)
			`CHK(interrupt_n_out, 1'b0)
			cmp <= BASE;
			repeat (8) @(posedge clk_sys);
			host_inst.service(q);
			`CHK(interrupt_n_out, 1'b1)
		end
		host_inst.xfer(1'b1, 4'h8, 32'h4, q);
		cmp <= BASE ^ 23'h800;
		repeat (8) @(posedge clk_sys);
		`CHK(interrupt_n_out, 1'b1)
		$display("interrupt sources done");
		n = 0;
		repeat (402) begin
			@(posedge clk_sys);
			if (healthActive === 1'b1)
				n++;
		end
		`CHK(n, 1)
		$display("health check done");
		arst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		`CHK({fuseEnable, boostEnable, buckEnable, blocking_switch, refEnable, healthActive,
			power_loss_flag, storage_power_good, interrupt_n_out}, 9'h001)
		arst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		host_inst.xfer(1'b0, 4'h8, 32'h0, q);
		`CHK(q, 32'h0)
		`CHK(ovSel, 3'h1)
		$display("reset done");
		end_of_test;
	end
endmodule
